//--- verilog/sprx_consts.vh
// Purpose: Shared constants of the receiver status and relock block
// Assumes: Included by bare name from every design file
// Notes: Register indices are word indices; byte address is four times the index
`ifndef SPRX_CONSTS_VH
`define SPRX_CONSTS_VH

// ==========================================================
// Register indices
`define SPRX_IDX_LOCK 16'hf600
`define SPRX_IDX_CTRL 16'hf601
`define SPRX_IDX_DECODE 16'hf602
`define SPRX_IDX_COMPR 16'hf603
`define SPRX_IDX_RESTART 16'hf604
`define SPRX_IDX_LOSTLOCK 16'hf605
`define SPRX_IDX_IRQ_STAT 16'hf606
`define SPRX_IDX_IRQ_MASK 16'hf607
`define SPRX_ADR_W 18
`define SPRX_RST16 16'h0000

// ==========================================================
// Field positions
`define SPRX_CTRL_W 4
`define SPRX_CTRL_QUICK 3
`define SPRX_RESTART_BIT 0
`define SPRX_DEC_W 10
`define SPRX_DEC_RWL_HI 9
`define SPRX_DEC_RWL_LO 6
`define SPRX_DEC_LWL_HI 5
`define SPRX_DEC_LWL_LO 2
`define SPRX_DEC_FAM 1
`define SPRX_DEC_TYPE 0

// ==========================================================
// Interrupt status bits
`define SPRX_IRQ_W 3
`define SPRX_IRQ_LOST 0
`define SPRX_IRQ_ACQ 1
`define SPRX_IRQ_FMT 2

// ==========================================================
// Lock qualification and stream decode
`define SPRX_LOCK_CNT_W 7
`define SPRX_LOCK_NORMAL 7'h40
`define SPRX_LOCK_FAST 7'h08
`define SPRX_CS_TYPE_BIT 8'h01
`define SPRX_CS_WL_FIRST 8'h20
`define SPRX_CS_WL_LAST 8'h23
`define SPRX_FAM2_LO 5'h0b
`define SPRX_FAM2_HI 5'h0d

`endif

//--- verilog/sprx_lock_qual.v
// Purpose: Declares lock after a run of consecutive valid samples
// Assumes: Sample strobes come from logic on clk_i
// Notes: One bad sample drops lock at once
`timescale 1ns/10ps
`include "sprx_consts.vh"

module sprx_lock_qual #(
  parameter W = `SPRX_LOCK_CNT_W,
  parameter [W-1:0] NORMAL_CNT = `SPRX_LOCK_NORMAL,
  parameter [W-1:0] FAST_CNT = `SPRX_LOCK_FAST
) (
  input wire clk_i,
  input wire rst_i,
  input wire sample_stb_i,
  input wire sample_ok_i,
  input wire quick_i,
  output wire lock_o,
  output wire lost_o,
  output wire acq_o
);

  reg [W-1:0] run_r;
  reg lock_r;
  reg lost_r;
  reg acq_r;
  wire [W-1:0] target = quick_i ? FAST_CNT : NORMAL_CNT;

  // ==========================================================
  // Run counter and lock state
  always @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= {W{1'b0}};
      lock_r <= 1'b0;
      lost_r <= 1'b0;
      acq_r <= 1'b0;
    end else begin
      lost_r <= 1'b0;
      acq_r <= 1'b0;
      if (sample_stb_i) begin
        if (sample_ok_i) begin
          if (!lock_r) begin
            if (run_r == target - {{(W-1){1'b0}}, 1'b1}) begin
              lock_r <= 1'b1;
              acq_r <= 1'b1;
              run_r <= {W{1'b0}};
            end else begin
              run_r <= run_r + {{(W-1){1'b0}}, 1'b1};
            end
          end
        end else begin
          run_r <= {W{1'b0}};
          if (lock_r) begin
            lock_r <= 1'b0;
            lost_r <= 1'b1;
          end
        end
      end
    end
  end

  assign lock_o = lock_r;
  assign lost_o = lost_r;
  assign acq_o = acq_r;

endmodule // sprx_lock_qual

//--- verilog/sprx_cs_decode.v
// Purpose: Decodes channel status and burst info into format fields
// Assumes: Subframe strobes come from logic on clk_i
// Notes: Word lengths publish after frame 35 of each block
`timescale 1ns/10ps
`include "sprx_consts.vh"

module sprx_cs_decode (
  input wire clk_i,
  input wire rst_i,
  input wire sub_stb_i,
  input wire sub_right_i,
  input wire cs_bit_i,
  input wire block_start_i,
  input wire burst_stb_i,
  input wire [15:0] burst_info_i,
  output wire [`SPRX_DEC_W-1:0] decode_o,
  output wire [15:0] code_o,
  output wire changed_o
);

  reg [7:0] frame_r;
  reg [3:0] wl_l_r;
  reg [3:0] wl_r_r;
  reg type_r;
  reg [`SPRX_DEC_W-1:0] dec_r;
  reg [15:0] code_r;
  reg chg_r;
  wire [7:0] fidx = block_start_i ? 8'h00 : frame_r;
  wire in_wl = (fidx >= `SPRX_CS_WL_FIRST) && (fidx <= `SPRX_CS_WL_LAST);
  wire [4:0] dtype = burst_info_i[4:0];
  wire fam2 = (dtype >= `SPRX_FAM2_LO) && (dtype <= `SPRX_FAM2_HI);
  wire [`SPRX_DEC_W-1:0] pub = {{cs_bit_i, wl_r_r[2:0]}, wl_l_r, dec_r[`SPRX_DEC_FAM], type_r};

  // ==========================================================
  // Channel status capture, update at frame 35 of each block
  always @(posedge clk_i) begin
    if (rst_i) begin
      frame_r <= 8'h00;
      wl_l_r <= 4'h0;
      wl_r_r <= 4'h0;
      type_r <= 1'b0;
      dec_r <= {`SPRX_DEC_W{1'b0}};
      code_r <= 16'h0000;
      chg_r <= 1'b0;
    end else begin
      chg_r <= 1'b0;
      if (sub_stb_i) begin
        if (!sub_right_i) begin
          frame_r <= fidx;
          if (fidx == `SPRX_CS_TYPE_BIT)
            type_r <= cs_bit_i;
          if (in_wl)
            wl_l_r[fidx[1:0]] <= cs_bit_i;
        end else begin
          frame_r <= fidx + 8'h01;
          if (in_wl)
            wl_r_r[fidx[1:0]] <= cs_bit_i;
          if (fidx == `SPRX_CS_WL_LAST) begin
            dec_r <= type_r ? pub : {pub[`SPRX_DEC_W-1:2], 2'b00};
            if (!type_r)
              code_r <= 16'h0000;
            chg_r <= (pub != dec_r);
          end
        end
      end
      if (burst_stb_i && dec_r[`SPRX_DEC_TYPE]) begin
        code_r <= burst_info_i;
        dec_r[`SPRX_DEC_FAM] <= fam2;
      end
    end
  end

  assign decode_o = dec_r;
  assign code_o = code_r;
  assign changed_o = chg_r;

endmodule // sprx_cs_decode

//--- verilog/sprx_top.v
// Purpose: Receiver status, format decode, mute and relock control
// Assumes: Classic Wishbone slave, 32-bit data, word index = adr_i[17:2]
// Notes: Front-end strobes are synchronous to clk_i
//        Unmapped indices read zero and are still answered
//        Audio stays muted from reset until the first lock
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/10ps
`include "sprx_consts.vh"

module sprx_top (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`SPRX_ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire sample_stb_i,
  input wire sample_ok_i,
  input wire sub_stb_i,
  input wire sub_right_i,
  input wire cs_bit_i,
  input wire block_start_i,
  input wire burst_stb_i,
  input wire [15:0] burst_info_i,
  output wire lock_o,
  output wire mute_o,
  output wire irq_o
);

  // ==========================================================
  // Byte lane merge of a 16-bit register
  function [15:0] lane16;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0] sel;
    begin
      lane16[7:0] = sel[0] ? new_v[7:0] : old_v[7:0];
      lane16[15:8] = sel[1] ? new_v[15:8] : old_v[15:8];
    end
  endfunction

  // ==========================================================
  // State
  reg ack_r;
  reg [31:0] dat_r;
  reg [`SPRX_CTRL_W-1:0] ctrl_r;
  reg restart_r;
  reg sticky_r;
  reg hold_r;
  reg mute_r;
  reg lock_out_r;
  reg [`SPRX_IRQ_W-1:0] istat_r;
  reg [`SPRX_IRQ_W-1:0] imask_r;
  reg irq_r;

  reg [`SPRX_CTRL_W-1:0] ctrl_nxt;
  reg restart_nxt;
  reg sticky_nxt;
  reg hold_nxt;
  reg [`SPRX_IRQ_W-1:0] istat_nxt;
  reg [`SPRX_IRQ_W-1:0] imask_nxt;
  reg [15:0] rd_nxt;
  reg [15:0] wmerge;
  reg mute_nxt;
  reg irq_nxt;

  wire lock_w;
  wire lost_w;
  wire acq_w;
  wire [`SPRX_DEC_W-1:0] decode_w;
  wire [15:0] code_w;
  wire fmt_chg_w;

  wire [15:0] idx = wb_adr_i[`SPRX_ADR_W-1:2];
  wire req = wb_cyc_i && wb_stb_i;
  wire wr_go = req && wb_we_i && ack_r;
  wire rd_go = req && !ack_r;
  wire [`SPRX_IRQ_W-1:0] events;
  wire resume_w = restart_r && lock_w;

  // ==========================================================
  // Lock qualifier
  sprx_lock_qual u_lock (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sample_stb_i(sample_stb_i),
    .sample_ok_i(sample_ok_i),
    .quick_i(ctrl_r[`SPRX_CTRL_QUICK]),
    .lock_o(lock_w),
    .lost_o(lost_w),
    .acq_o(acq_w)
  );

  // ==========================================================
  // Channel status decoder
  sprx_cs_decode u_dec (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sub_stb_i(sub_stb_i),
    .sub_right_i(sub_right_i),
    .cs_bit_i(cs_bit_i),
    .block_start_i(block_start_i),
    .burst_stb_i(burst_stb_i),
    .burst_info_i(burst_info_i),
    .decode_o(decode_w),
    .code_o(code_w),
    .changed_o(fmt_chg_w)
  );

  assign events = {fmt_chg_w, acq_w, lost_w};

  // ==========================================================
  // Register writes and interrupt status update
  always @* begin
    ctrl_nxt = ctrl_r;
    restart_nxt = restart_r;
    imask_nxt = imask_r;
    istat_nxt = istat_r;
    wmerge = 16'h0000;
    if (wr_go) begin
      case (idx)
        `SPRX_IDX_CTRL: begin
          wmerge = lane16({12'h000, ctrl_r}, wb_dat_i[15:0], wb_sel_i[1:0]);
          ctrl_nxt = wmerge[`SPRX_CTRL_W-1:0];
        end
        `SPRX_IDX_RESTART: begin
          wmerge = lane16({15'h0000, restart_r}, wb_dat_i[15:0], wb_sel_i[1:0]);
          restart_nxt = wmerge[`SPRX_RESTART_BIT];
        end
        `SPRX_IDX_IRQ_MASK: begin
          wmerge = lane16({13'h0000, imask_r}, wb_dat_i[15:0], wb_sel_i[1:0]);
          imask_nxt = wmerge[`SPRX_IRQ_W-1:0];
        end
        `SPRX_IDX_IRQ_STAT: begin
          wmerge = lane16(16'h0000, wb_dat_i[15:0], wb_sel_i[1:0]);
          istat_nxt = istat_r & ~wmerge[`SPRX_IRQ_W-1:0];
        end
        default: begin
          wmerge = 16'h0000;
        end
      endcase
    end
    // A new event wins over a clear in the same cycle
    istat_nxt = istat_nxt | events;
  end

  // ==========================================================
  // Sticky loss flag; loss wins over a restart clear
  always @* begin
    if (lost_w) begin
      sticky_nxt = 1'b1;
    end else if (resume_w) begin
      sticky_nxt = 1'b0;
    end else begin
      sticky_nxt = sticky_r;
    end
  end

  // ==========================================================
  // Audio hold after a loss, released by restart at relock
  always @* begin
    if (lost_w) begin
      hold_nxt = 1'b1;
    end else if (resume_w) begin
      hold_nxt = 1'b0;
    end else begin
      hold_nxt = hold_r;
    end
  end

  // ==========================================================
  // Pin next values
  always @* begin
    mute_nxt = !lock_w || hold_nxt;
    irq_nxt = |(istat_nxt & imask_nxt);
  end

  // ==========================================================
  // Read data mux
  always @* begin
    case (idx)
      `SPRX_IDX_LOCK: begin
        rd_nxt = {15'h0000, lock_w};
      end
      `SPRX_IDX_CTRL: begin
        rd_nxt = {12'h000, ctrl_r};
      end
      `SPRX_IDX_DECODE: begin
        rd_nxt = {6'h00, decode_w};
      end
      `SPRX_IDX_COMPR: begin
        rd_nxt = code_w;
      end
      `SPRX_IDX_RESTART: begin
        rd_nxt = {15'h0000, restart_r};
      end
      `SPRX_IDX_LOSTLOCK: begin
        rd_nxt = {15'h0000, sticky_r};
      end
      `SPRX_IDX_IRQ_STAT: begin
        rd_nxt = {13'h0000, istat_r};
      end
      `SPRX_IDX_IRQ_MASK: begin
        rd_nxt = {13'h0000, imask_r};
      end
      default: begin
        rd_nxt = `SPRX_RST16;
      end
    endcase
  end

  // ==========================================================
  // Bus answer flops
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= rd_go;
      if (rd_go) begin
        dat_r <= {16'h0000, rd_nxt};
      end
    end
  end

  // ==========================================================
  // Software controlled registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= {`SPRX_CTRL_W{1'b0}};
      restart_r <= 1'b0;
      imask_r <= {`SPRX_IRQ_W{1'b0}};
    end else begin
      ctrl_r <= ctrl_nxt;
      restart_r <= restart_nxt;
      imask_r <= imask_nxt;
    end
  end

  // ==========================================================
  // Relock state and pin flops
  always @(posedge clk_i) begin
    if (rst_i) begin
      sticky_r <= 1'b0;
      hold_r <= 1'b0;
      mute_r <= 1'b1;
      lock_out_r <= 1'b0;
    end else begin
      sticky_r <= sticky_nxt;
      hold_r <= hold_nxt;
      mute_r <= mute_nxt;
      lock_out_r <= lock_w;
    end
  end

  // ==========================================================
  // Interrupt status and line
  always @(posedge clk_i) begin
    if (rst_i) begin
      istat_r <= {`SPRX_IRQ_W{1'b0}};
      irq_r <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign lock_o = lock_out_r;
  assign mute_o = mute_r;
  assign irq_o = irq_r;

endmodule // sprx_top

//--- dv/sprx_checker.sv
// Purpose: Port checker for sprx_top
// Assumes: Bound from tb; synchronous reset disables every property
// Notes: Latencies follow the registered outputs of the design
`timescale 1ns/10ps
`include "sprx_consts.vh"
module sprx_checker (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`SPRX_ADR_W-1:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire sample_stb_i,
  input wire sample_ok_i,
  input wire lock_o,
  input wire mute_o,
  input wire irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ======
  // Bus
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[17:5] != 13'h1ec0
    |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // ======
  // Lock and mute
  a_bad_mutes: assert property (sample_stb_i && !sample_ok_i |=> ##1 (mute_o && !lock_o))
    else $error("bad sample not muted");
  a_unlock_mute: assert property (!lock_o |-> mute_o)
    else $error("unmuted without lock");
  a_lock_cause: assert property ($rose(lock_o) |-> $past(sample_stb_i, 2) && $past(sample_ok_i, 2))
    else $error("lock without good sample");
  a_drop_cause: assert property ($fell(lock_o) |-> $past(sample_stb_i, 2) && !$past(sample_ok_i, 2))
    else $error("lock lost without bad sample");
  c_lock: cover property ($rose(lock_o));
  c_unmute: cover property ($fell(mute_o));
  c_irq: cover property ($rose(irq_o));
endmodule // sprx_checker

//--- dv/sprx_src_model.sv
// Purpose: Behavioural stream source feeding the receiver front-end strobes
// Assumes: Strobes one cycle wide with an idle cycle between
// Notes: Idle data lines show the inverse of the last value
`timescale 1ns/10ps
module sprx_src_model (
  input wire clk_i,
  output logic sample_stb_o = 1'b0,
  output logic sample_ok_o = 1'b0,
  output logic sub_stb_o = 1'b0,
  output logic sub_right_o = 1'b0,
  output logic cs_bit_o = 1'b0,
  output logic block_start_o = 1'b0,
  output logic burst_stb_o = 1'b0,
  output logic [15:0] burst_info_o = 16'h0
);
  task automatic samples(input int n, input logic ok);
    repeat (n) begin
      @(posedge clk_i);
      sample_stb_o <= 1'b1;
      sample_ok_o <= ok;
      @(posedge clk_i);
      sample_stb_o <= 1'b0;
      sample_ok_o <= ~ok;
    end
  endtask
  task automatic sub(input logic rt, input logic cs, input logic bs);
    @(posedge clk_i);
    sub_stb_o <= 1'b1;
    sub_right_o <= rt;
    cs_bit_o <= cs;
    block_start_o <= bs;
    @(posedge clk_i);
    sub_stb_o <= 1'b0;
    sub_right_o <= ~rt;
    cs_bit_o <= ~cs;
    block_start_o <= ~bs;
  endtask
  // Word length nibble sent in frames 32 to 35, lsb first
  task automatic block(input logic typ, input logic [3:0] wl, input logic [3:0] wr);
    for (int f = 0; f < 36; f++) begin
      sub(1'b0, f == 1 ? typ : (f >= 32 ? wl[f[1:0]] : 1'b0), f == 0);
      sub(1'b1, f >= 32 ? wr[f[1:0]] : 1'b0, 1'b0);
    end
  endtask
  task automatic burst(input logic [15:0] v);
    @(posedge clk_i);
    burst_stb_o <= 1'b1;
    burst_info_o <= v;
    @(posedge clk_i);
    burst_stb_o <= 1'b0;
    burst_info_o <= ~v;
  endtask
endmodule // sprx_src_model

//--- dv/sprx_tb.sv
// Purpose: Self-checking bench for sprx_top
// Assumes: Byte address is register index times four
// Notes: Output pins compared as one {lock, mute, irq} triple
`timescale 1ns/10ps
module tb;
  logic clk_i, rst_i, cyc, stb, we, ack, lock, mute, irq;
  logic s_stb, s_ok, u_stb, u_rt, csb, bst, b_stb;
  logic [17:0] adr;
  logic [3:0] sel;
  logic [15:0] binfo;
  logic [31:0] wdat, rdat, dat_o;
  int err_count = 0;
  int checks = 0;
  sprx_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .sample_stb_i(s_stb), .sample_ok_i(s_ok), .sub_stb_i(u_stb), .sub_right_i(u_rt),
    .cs_bit_i(csb), .block_start_i(bst), .burst_stb_i(b_stb), .burst_info_i(binfo),
    .lock_o(lock), .mute_o(mute), .irq_o(irq));
  sprx_src_model u_src (.clk_i(clk_i), .sample_stb_o(s_stb), .sample_ok_o(s_ok),
    .sub_stb_o(u_stb), .sub_right_o(u_rt), .cs_bit_o(csb), .block_start_o(bst),
    .burst_stb_o(b_stb), .burst_info_o(binfo));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // ======
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] idx, input logic [15:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {16'h0, d};
    sel <= s;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 16'h0, 4'hf);
    chk(rdat, exp);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    bus(1'b1, idx, d, 4'hf);
  endtask
  task automatic pins(input logic l, input logic m, input logic i);
    repeat (3) @(posedge clk_i);
    chk({29'h0, lock, mute, irq}, {29'h0, l, m, i});
  endtask
  // ======
  // Scenarios
  task automatic t_reset;
    logic [15:0] ro [5] = '{16'hf600, 16'hf602, 16'hf603, 16'hf605, 16'hf610};
    for (int i = 16'hf600; i < 16'hf608; i++) rd(16'(i), 32'h0);
    pins(1'b0, 1'b1, 1'b0);
    foreach (ro[i]) begin
      wr(ro[i], 16'hffff);
      rd(ro[i], 32'h0);
    end
    $display("test reset done");
  endtask
  task automatic t_lock;
    u_src.samples(63, 1'b1);
    pins(1'b0, 1'b1, 1'b0);
    u_src.samples(1, 1'b1);
    pins(1'b1, 1'b0, 1'b0);
    rd(16'hf600, 32'h1);
    rd(16'hf605, 32'h0);
    rd(16'hf606, 32'h2);
    $display("test lock done");
  endtask
  task automatic t_loss;
    wr(16'hf607, 16'h1);
    bus(1'b1, 16'hf607, 16'hffff, 4'h2);
    rd(16'hf607, 32'h1);
    u_src.samples(1, 1'b0);
    pins(1'b0, 1'b1, 1'b1);
    rd(16'hf605, 32'h1);
    u_src.samples(64, 1'b1);
    pins(1'b1, 1'b1, 1'b1);
    rd(16'hf605, 32'h1);
    wr(16'hf606, 16'h1);
    pins(1'b1, 1'b1, 1'b0);
    rd(16'hf606, 32'h2);
    wr(16'hf604, 16'h1);
    rd(16'hf605, 32'h0);
    wr(16'hf604, 16'h0);
    pins(1'b1, 1'b0, 1'b0);
    $display("test loss done");
  endtask
  task automatic t_auto;
    wr(16'hf601, 16'h8);
    wr(16'hf604, 16'h1);
    rd(16'hf604, 32'h1);
    u_src.samples(1, 1'b0);
    pins(1'b0, 1'b1, 1'b1);
    rd(16'hf605, 32'h1);
    u_src.samples(7, 1'b1);
    pins(1'b0, 1'b1, 1'b1);
    u_src.samples(1, 1'b1);
    pins(1'b1, 1'b0, 1'b1);
    rd(16'hf605, 32'h0);
    wr(16'hf606, 16'h7);
    wr(16'hf604, 16'h0);
    pins(1'b1, 1'b0, 1'b0);
    $display("test auto done");
  endtask
  task automatic t_decode;
    u_src.block(1'b1, 4'b0010, 4'b1011);
    rd(16'hf602, {22'h0, 4'b1011, 4'b0010, 2'b01});
    rd(16'hf606, 32'h4);
    u_src.burst(16'h000b);
    rd(16'hf602, {22'h0, 4'b1011, 4'b0010, 2'b11});
    rd(16'hf603, 32'h000b);
    u_src.burst(16'h1a01);
    rd(16'hf602, {22'h0, 4'b1011, 4'b0010, 2'b01});
    rd(16'hf603, 32'h1a01);
    u_src.block(1'b0, 4'b1100, 4'b0011);
    rd(16'hf602, {22'h0, 4'b0011, 4'b1100, 2'b00});
    u_src.burst(16'h000c);
    rd(16'hf603, 32'h0);
    $display("test decode done");
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #(8 * 8000);
    err_count++;
    close_out;
  end
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 18'h0;
    sel = 4'h0;
    wdat = 32'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_lock;
    t_loss;
    t_auto;
    t_decode;
    close_out;
  end
endmodule // tb
bind sprx_top sprx_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .sample_stb_i(sample_stb_i), .sample_ok_i(sample_ok_i),
  .lock_o(lock_o), .mute_o(mute_o), .irq_o(irq_o));
